// *** src/cp_ops_pkg.sv ***
/*
 * constants shared by the bit, skip, branch and control-order unit:
 * operation codes, widths, register geometry.
 * assumes one system clock and a synchronous active-high reset.
 */
package cp_ops_pkg;

	localparam int WORD_W   = 32;
	localparam int ADDR_W   = 19;
	localparam int REG_NUM  = 16;
	localparam int REG_AW   = 4;
	localparam int HALF_W   = 16;
	localparam int BIT_AW   = 4;
	localparam int OP_W     = 6;

	localparam logic [ADDR_W-1:0] PC_RESET = 19'h00000;
	localparam logic [WORD_W-1:0] REG_RESET = 32'h00000000;

	// step sizes for loop-index branches
	localparam logic [WORD_W-1:0] STEP_HALF   = 32'h00000001;
	localparam logic [WORD_W-1:0] STEP_WORD   = 32'h00000002;
	localparam logic [WORD_W-1:0] STEP_DOUBLE = 32'h00000004;

	typedef enum logic [OP_W-1:0] {
		OP_NOP,
		OP_UNPACK_LEFT,
		OP_UNPACK_RIGHT,
		OP_CLEAR_SELECTED_BIT,
		OP_SET_SELECTED_BIT,
		OP_INVERT_SELECTED_BIT,
		OP_SKIP_IF_BIT_ZERO,
		OP_SKIP_IF_BIT_ZERO_THEN_CLEAR,
		OP_SKIP_IF_BIT_ZERO_THEN_SET,
		OP_SKIP_IF_BIT_ZERO_THEN_FLIP,
		OP_SKIP_IF_BIT_ONE,
		OP_SKIP_IF_BIT_ONE_THEN_CLEAR,
		OP_SKIP_IF_BIT_ONE_THEN_SET,
		OP_SKIP_IF_BIT_ONE_THEN_FLIP,
		OP_BRANCH_REG_ZERO,
		OP_BRANCH_REG_NONZERO,
		OP_BRANCH_REG_POSITIVE,
		OP_BRANCH_REG_AT_MOST_ZERO,
		OP_BRANCH_REG_NEGATIVE,
		OP_BRANCH_REG_AT_LEAST_ZERO,
		OP_BRANCH_CC_EQUAL,
		OP_BRANCH_CC_UNEQUAL,
		OP_BRANCH_CC_GREATER,
		OP_BRANCH_CC_LESS_OR_EQUAL,
		OP_BRANCH_CC_LESS,
		OP_BRANCH_CC_GREATER_OR_EQUAL,
		OP_BRANCH_CC_IMPLICATION,
		OP_BRANCH_CC_NO_IMPLICATION,
		OP_STEP_UP_HALF_AND_BRANCH,
		OP_STEP_DOWN_HALF_AND_BRANCH,
		OP_STEP_UP_WORD_AND_BRANCH,
		OP_STEP_DOWN_WORD_AND_BRANCH,
		OP_STEP_UP_DOUBLE_AND_BRANCH,
		OP_STEP_DOWN_DOUBLE_AND_BRANCH,
		OP_LINK_THEN_BRANCH,
		OP_EXECUTE_REMOTE_INSTRUCTION,
		OP_SWAP_PROGRAM_STATEWORDS,
		OP_PROCESS_ORDER_SEND
	} op_type;

endpackage

// *** src/cp_condition_eval.sv ***
/*
 * combinational branch-condition evaluator for register tests and
 * condition-code tests.
 * assumes the opcode and operands are stable for the cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module cp_condition_eval
	import cp_ops_pkg::*;
(
	// operation and operands
	input  wire op_type            op_i,
	input  wire logic [WORD_W-1:0] reg_value_i,
	input  wire logic [1:0]        cc_i,
	// result
	output logic                   take_o
);

	wire reg_zero = (reg_value_i == '0);
	wire reg_neg  = reg_value_i[WORD_W-1];
	wire cc_first = cc_i[1];
	wire cc_second = cc_i[0];

	always_comb begin
		case (op_i)
			OP_BRANCH_REG_ZERO:            take_o = reg_zero;
			OP_BRANCH_REG_NONZERO:         take_o = !reg_zero;
			OP_BRANCH_REG_POSITIVE:        take_o = !reg_zero && !reg_neg;
			OP_BRANCH_REG_AT_MOST_ZERO:    take_o = reg_zero || reg_neg;
			OP_BRANCH_REG_NEGATIVE:        take_o = reg_neg;
			OP_BRANCH_REG_AT_LEAST_ZERO:   take_o = !reg_neg;
			OP_BRANCH_CC_GREATER:          take_o = cc_second;
			OP_BRANCH_CC_LESS_OR_EQUAL:    take_o = !cc_second;
			OP_BRANCH_CC_LESS:             take_o = cc_first;
			OP_BRANCH_CC_GREATER_OR_EQUAL: take_o = !cc_first;
			OP_BRANCH_CC_EQUAL:            take_o = (cc_i == 2'h0);
			OP_BRANCH_CC_UNEQUAL:          take_o = (cc_i != 2'h0);
			OP_BRANCH_CC_IMPLICATION:      take_o = (cc_i == 2'h3);
			OP_BRANCH_CC_NO_IMPLICATION:   take_o = (cc_i != 2'h3);
			default:                       take_o = 1'b0;
		endcase
	end

endmodule

`default_nettype wire

// *** src/cp_bit_branch_control_ops.sv ***
/*
 * execution unit for unpack, bit, skip, branch, loop-index and control
 * orders. holds the general registers and instruction address; storage
 * is reached by a request/acknowledge port toward the memory access
 * director, process orders by a request/acknowledge port toward the
 * multiprocess controller.
 * assumes both partners hold acknowledge low except to answer a request.
 */
// Operation
// - unpack zeroes target register, then double shift
// - bit zero skips once; variants modify bit
// - bit one skips once; variants modify bit
// - register versus zero tests load branch address
// - condition indicator tests select branch
// - equal, unequal, implication test indicator pair
// - step register, branch unless index bit changes
// - process order sends address to controller
`timescale 1ns/1ps
`default_nettype none

module cp_bit_branch_control_ops
	import cp_ops_pkg::*;
#(
	parameter int INDEX_BIT = 0
) (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// instruction from sequencing
	input  wire logic              issue_i,
	input  wire op_type            op_i,
	input  wire logic [REG_AW-1:0] reg_sel_i,
	input  wire logic [ADDR_W-1:0] eff_addr_i,
	input  wire logic [5:0]        shift_count_i,
	input  wire logic [1:0]        cc_i,
	output logic                   busy_o,
	output logic                   done_o,
	output logic                   remote_exec_o,
	output logic [ADDR_W-1:0]      iaddr_o,
	// storage port
	output logic                   mem_req_o,
	output logic                   mem_we_o,
	output logic [ADDR_W-1:0]      mem_addr_o,
	output logic [WORD_W-1:0]      mem_wdata_o,
	input  wire logic              mem_ack_i,
	input  wire logic [WORD_W-1:0] mem_rdata_i,
	// program statewords and process orders
	input  wire logic [WORD_W-1:0] ps1_i,
	input  wire logic [WORD_W-1:0] ps2_i,
	output logic [WORD_W-1:0]      ps1_o,
	output logic [WORD_W-1:0]      ps2_o,
	output logic                   ps_load_o,
	output logic                   order_req_o,
	output logic [ADDR_W-1:0]      order_addr_o,
	input  wire logic              order_ack_i
);

	typedef enum logic [2:0] {
		ST_IDLE, ST_READ, ST_WRITE, ST_SWAP_RD2, ST_SWAP_WR1, ST_SWAP_WR2,
		ST_ORDER
	} state_type;

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [WORD_W-1:0] regs_q [REG_NUM];
	state_type         state_q;
	op_type            op_q;
	logic [REG_AW-1:0] rsel_q;
	logic [ADDR_W-1:0] ea_q;
	logic [WORD_W-1:0] word_q;
	logic [WORD_W-1:0] ps1_q;
	logic [WORD_W-1:0] ps2_q;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire accept = issue_i && (state_q == ST_IDLE);
	wire [WORD_W-1:0] rval = regs_q[reg_sel_i];
	wire [REG_AW-1:0] rnext = reg_sel_i + 4'h1;
	wire [WORD_W-1:0] rval2 = regs_q[rnext];
	wire cond_take;

	cp_condition_eval u_cond (
		.op_i        (op_i),
		.reg_value_i (rval),
		.cc_i        (cc_i),
		.take_o      (cond_take)
	);

	// halfword select by the low address bit, bit select by reg field
	wire [HALF_W-1:0] half_sel = ea_q[0] ? mem_rdata_i[HALF_W-1:0]
		: mem_rdata_i[WORD_W-1:HALF_W];
	wire [BIT_AW-1:0] bit_idx = BIT_AW'(HALF_W - 1) - rsel_q;
	wire cur_bit = half_sel[bit_idx];
	wire is_zero_skip = (op_q >= OP_SKIP_IF_BIT_ZERO) &&
		(op_q <= OP_SKIP_IF_BIT_ZERO_THEN_FLIP);
	wire is_one_skip = (op_q >= OP_SKIP_IF_BIT_ONE) &&
		(op_q <= OP_SKIP_IF_BIT_ONE_THEN_FLIP);
	wire skip_take = (is_zero_skip && !cur_bit) ||
		(is_one_skip && cur_bit);
	wire set_ops = (op_q == OP_SET_SELECTED_BIT) ||
		(op_q == OP_SKIP_IF_BIT_ZERO_THEN_SET) ||
		(op_q == OP_SKIP_IF_BIT_ONE_THEN_SET);
	wire clr_ops = (op_q == OP_CLEAR_SELECTED_BIT) ||
		(op_q == OP_SKIP_IF_BIT_ZERO_THEN_CLEAR) ||
		(op_q == OP_SKIP_IF_BIT_ONE_THEN_CLEAR);
	wire flip_ops = (op_q == OP_INVERT_SELECTED_BIT) ||
		(op_q == OP_SKIP_IF_BIT_ZERO_THEN_FLIP) ||
		(op_q == OP_SKIP_IF_BIT_ONE_THEN_FLIP);
	wire new_bit = set_ops ? 1'b1 : (clr_ops ? 1'b0 : !cur_bit);
	wire modifies = set_ops || clr_ops || flip_ops;
	wire [4:0] word_pos = {~ea_q[0], bit_idx};
	logic [WORD_W-1:0] mod_word;
	always_comb begin
		mod_word = mem_rdata_i;
		mod_word[word_pos] = new_bit;
	end

	// loop-index step: add or subtract 1, 2 or 4
	wire step_up = (op_i == OP_STEP_UP_HALF_AND_BRANCH) ||
		(op_i == OP_STEP_UP_WORD_AND_BRANCH) ||
		(op_i == OP_STEP_UP_DOUBLE_AND_BRANCH);
	wire step_dn = (op_i == OP_STEP_DOWN_HALF_AND_BRANCH) ||
		(op_i == OP_STEP_DOWN_WORD_AND_BRANCH) ||
		(op_i == OP_STEP_DOWN_DOUBLE_AND_BRANCH);
	wire [WORD_W-1:0] step_amt =
		((op_i == OP_STEP_UP_HALF_AND_BRANCH) ||
		 (op_i == OP_STEP_DOWN_HALF_AND_BRANCH)) ? STEP_HALF :
		((op_i == OP_STEP_UP_WORD_AND_BRANCH) ||
		 (op_i == OP_STEP_DOWN_WORD_AND_BRANCH)) ? STEP_WORD : STEP_DOUBLE;
	wire [WORD_W-1:0] stepped = step_up ? rval + step_amt
		: rval - step_amt;
	wire index_kept = (stepped[INDEX_BIT] == rval[INDEX_BIT]);

	// unpack: double shift of a pair with the receiving half zeroed first
	// left moves R+1 into a cleared R, right moves R into a cleared R+1
	wire [2*WORD_W-1:0] pair_left = {{WORD_W{1'b0}}, rval2} <<
		shift_count_i;
	wire [2*WORD_W-1:0] pair_right = {rval, {WORD_W{1'b0}}} >>
		shift_count_i;

	wire [ADDR_W-1:0] iaddr_inc = iaddr_o + 19'h00001;
	wire [ADDR_W-1:0] iaddr_skip = iaddr_o + 19'h00002;

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q       <= ST_IDLE;
			op_q          <= OP_NOP;
			rsel_q        <= '0;
			ea_q          <= PC_RESET;
			word_q        <= REG_RESET;
			ps1_q         <= REG_RESET;
			ps2_q         <= REG_RESET;
			iaddr_o       <= PC_RESET;
			busy_o        <= 1'b0;
			done_o        <= 1'b0;
			remote_exec_o <= 1'b0;
			mem_req_o     <= 1'b0;
			mem_we_o      <= 1'b0;
			mem_addr_o    <= PC_RESET;
			mem_wdata_o   <= REG_RESET;
			ps1_o         <= REG_RESET;
			ps2_o         <= REG_RESET;
			ps_load_o     <= 1'b0;
			order_req_o   <= 1'b0;
			order_addr_o  <= PC_RESET;
			for (int i = 0; i < REG_NUM; i++) begin
				regs_q[i] <= REG_RESET;
			end
		end else begin
			done_o        <= 1'b0;
			remote_exec_o <= 1'b0;
			ps_load_o     <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (accept) begin
						op_q   <= op_i;
						rsel_q <= reg_sel_i;
						ea_q   <= eff_addr_i;
						case (op_i)
							OP_UNPACK_LEFT: begin
								regs_q[reg_sel_i] <= pair_left[2*WORD_W-1:WORD_W];
								regs_q[rnext]     <= pair_left[WORD_W-1:0];
								iaddr_o <= iaddr_inc;
								done_o  <= 1'b1;
							end
							OP_UNPACK_RIGHT: begin
								regs_q[reg_sel_i] <= pair_right[2*WORD_W-1:WORD_W];
								regs_q[rnext]     <= pair_right[WORD_W-1:0];
								iaddr_o <= iaddr_inc;
								done_o  <= 1'b1;
							end
							OP_LINK_THEN_BRANCH: begin
								regs_q[reg_sel_i] <= WORD_W'(iaddr_inc);
								iaddr_o <= eff_addr_i;
								done_o  <= 1'b1;
							end
							OP_EXECUTE_REMOTE_INSTRUCTION: begin
								// sequencing fetches the word at the address once
								iaddr_o       <= eff_addr_i;
								remote_exec_o <= 1'b1;
								done_o        <= 1'b1;
							end
							OP_PROCESS_ORDER_SEND: begin
								order_req_o  <= 1'b1;
								order_addr_o <= eff_addr_i;
								busy_o       <= 1'b1;
								state_q      <= ST_ORDER;
							end
							OP_NOP: begin
								iaddr_o <= iaddr_inc;
								done_o  <= 1'b1;
							end
							default: begin
								if (step_up || step_dn) begin
									regs_q[reg_sel_i] <= stepped;
									iaddr_o <= index_kept ? eff_addr_i : iaddr_inc;
									done_o  <= 1'b1;
								end else if (op_i >= OP_BRANCH_REG_ZERO &&
									op_i <= OP_BRANCH_CC_NO_IMPLICATION) begin
									iaddr_o <= cond_take ? eff_addr_i
										: iaddr_inc;
									done_o  <= 1'b1;
								end else begin
									// bit, skip and swap orders read storage first
									mem_req_o  <= 1'b1;
									mem_we_o   <= 1'b0;
									mem_addr_o <= (op_i == OP_SWAP_PROGRAM_STATEWORDS)
										? eff_addr_i : {1'b0, eff_addr_i[ADDR_W-1:1]};
									busy_o     <= 1'b1;
									state_q    <= ST_READ;
								end
							end
						endcase
					end
				end
				ST_READ: begin
					if (mem_ack_i) begin
						if (op_q == OP_SWAP_PROGRAM_STATEWORDS) begin
							word_q     <= mem_rdata_i;
							ps1_q      <= ps1_i;
							ps2_q      <= ps2_i;
							mem_addr_o <= ea_q + 19'h00001;
							state_q    <= ST_SWAP_RD2;
						end else begin
							iaddr_o <= skip_take ? iaddr_skip
								: iaddr_inc;
							if (modifies) begin
								mem_we_o    <= 1'b1;
								mem_wdata_o <= mod_word;
								state_q     <= ST_WRITE;
							end else begin
								mem_req_o <= 1'b0;
								busy_o    <= 1'b0;
								done_o    <= 1'b1;
								state_q   <= ST_IDLE;
							end
						end
					end
				end
				ST_SWAP_RD2: begin
					if (mem_ack_i) begin
						ps1_o       <= word_q;
						ps2_o       <= mem_rdata_i;
						ps_load_o   <= 1'b1;
						mem_we_o    <= 1'b1;
						mem_addr_o  <= ea_q;
						mem_wdata_o <= ps1_q;
						state_q     <= ST_SWAP_WR1;
					end
				end
				ST_SWAP_WR1: begin
					if (mem_ack_i) begin
						mem_addr_o  <= ea_q + 19'h00001;
						mem_wdata_o <= ps2_q;
						state_q     <= ST_SWAP_WR2;
					end
				end
				ST_WRITE, ST_SWAP_WR2: begin
					if (mem_ack_i) begin
						mem_req_o <= 1'b0;
						mem_we_o  <= 1'b0;
						busy_o    <= 1'b0;
						done_o    <= 1'b1;
						if (state_q == ST_SWAP_WR2) begin
							iaddr_o <= iaddr_inc;
						end
						state_q   <= ST_IDLE;
					end
				end
				ST_ORDER: begin
					// the order stands until the controller takes it
					if (order_ack_i) begin
						order_req_o <= 1'b0;
						busy_o      <= 1'b0;
						done_o      <= 1'b1;
						iaddr_o     <= iaddr_inc;
						state_q     <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

endmodule

`default_nettype wire

// *** verification/cp_ops_chk.sv ***
/* checker for the execution unit: storage and order handshakes and
   condition-code branch results. sees only the unit's top ports. */
`timescale 1ns/1ps
`default_nettype none
module cp_ops_chk
	import cp_ops_pkg::*;
(
	// clock and reset
	input wire logic              clk_i,
	input wire logic              rst_i,
	// instruction
	input wire logic              issue_i,
	input wire op_type            op_i,
	input wire logic [ADDR_W-1:0] eff_addr_i,
	input wire logic [1:0]        cc_i,
	input wire logic              busy_o,
	input wire logic              done_o,
	input wire logic [ADDR_W-1:0] iaddr_o,
	// storage and orders
	input wire logic              mem_req_o,
	input wire logic              mem_we_o,
	input wire logic [ADDR_W-1:0] mem_addr_o,
	input wire logic              mem_ack_i,
	input wire logic              order_req_o,
	input wire logic [ADDR_W-1:0] order_addr_o,
	input wire logic              order_ack_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic take;
	assign take = issue_i && !busy_o;
	// branch goes to the address when c held, else falls through
	property p_br(op_type op, logic c);
		take && op_i == op |=> iaddr_o ==
			($past(c) ? $past(eff_addr_i) : $past(iaddr_o) + 19'h1);
	endproperty
	AST_REQ_HOLD:
	assert property (mem_req_o && !mem_ack_i |=> mem_req_o &&
		$stable(mem_addr_o) && $stable(mem_we_o)) else $error("req moved");
	AST_SKIP_REQ:
	assert property (take && op_i inside {[OP_CLEAR_SELECTED_BIT:
		OP_SKIP_IF_BIT_ONE_THEN_FLIP]} |=> busy_o && mem_req_o && !mem_we_o
		&& mem_addr_o == {1'b0, $past(eff_addr_i[ADDR_W-1:1])})
		else $error("bit read wrong");
	AST_ORD_ADDR:
	assert property (take && op_i == OP_PROCESS_ORDER_SEND |=> busy_o &&
		order_req_o && order_addr_o == $past(eff_addr_i))
		else $error("order address wrong");
	AST_ORD_HOLD:
	assert property (order_req_o && !order_ack_i |=> order_req_o &&
		$stable(order_addr_o)) else $error("order moved");
	AST_ORD_DONE:
	assert property (order_req_o && order_ack_i |=> done_o && !order_req_o
		&& !busy_o) else $error("order not closed");
	AST_CC_EQ:
	assert property (p_br(OP_BRANCH_CC_EQUAL, cc_i == 2'b00))
		else $error("equal branch wrong");
	AST_CC_GT:
	assert property (p_br(OP_BRANCH_CC_GREATER, cc_i[0]))
		else $error("greater branch wrong");
	AST_CC_LT:
	assert property (p_br(OP_BRANCH_CC_LESS, cc_i[1]))
		else $error("less branch wrong");
	C_SKIP: cover property (take && op_i == OP_SKIP_IF_BIT_ONE_THEN_FLIP);
	C_WR: cover property (mem_req_o && mem_we_o && mem_ack_i);
	C_ORD: cover property (order_req_o && order_ack_i);
endmodule
bind cp_bit_branch_control_ops cp_ops_chk u_chk (.clk_i, .rst_i, .issue_i,
	.op_i, .eff_addr_i, .cc_i, .busy_o, .done_o, .iaddr_o, .mem_req_o,
	.mem_we_o, .mem_addr_o, .mem_ack_i, .order_req_o, .order_addr_o,
	.order_ack_i);
`default_nettype wire

// *** verification/mem_order_model.sv ***
/* storage and process-order partner: answers a request after lat_i
   idle cycles. assumes requests hold until acknowledged. */
`timescale 1ns/1ps
`default_nettype none
module mem_order_model
	import cp_ops_pkg::*;
(
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// storage
	input  wire logic              req_i,
	input  wire logic              we_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [WORD_W-1:0] wdata_i,
	output logic                   ack_o,
	output logic [WORD_W-1:0]      rdata_o,
	// orders
	input  wire logic              oreq_i,
	input  wire logic [ADDR_W-1:0] oaddr_i,
	output logic                   oack_o,
	input  wire logic [3:0]        lat_i
);
	logic [WORD_W-1:0] mem [16];
	logic [ADDR_W-1:0] oaddr_q;
	logic [3:0]        wait_q;
	wire logic         pend;
	assign pend = (req_i || oreq_i) && !ack_o && !oack_o;
	// plain always: the bench presets words directly
	always @(posedge clk_i) begin
		ack_o <= 1'b0;
		oack_o <= 1'b0;
		// data toggles off ack so stale reads never look valid
		rdata_o <= ~rdata_o;
		if (rst_i) begin
			wait_q <= 4'h0;
			rdata_o <= 32'h00000000;
		end else if (pend && wait_q < lat_i) begin
			wait_q <= wait_q + 4'h1;
		end else if (pend) begin
			wait_q <= 4'h0;
			ack_o <= req_i;
			oack_o <= !req_i;
			if (req_i && we_i)
				mem[addr_i[3:0]] <= wdata_i;
			if (req_i && !we_i)
				rdata_o <= mem[addr_i[3:0]];
			if (!req_i)
				oaddr_q <= oaddr_i;
		end
	end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
/* bench for the execution unit with the storage and order model.
   assumes a 10 MHz clock and synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module testbench
	import cp_ops_pkg::*;
;
	localparam int IB = 1;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic issue_i = 1'b0;
	op_type op_i = OP_NOP;
	logic [REG_AW-1:0] reg_sel_i = 4'h0;
	logic [ADDR_W-1:0] eff_addr_i = 19'h00000;
	logic [5:0] shift_count_i = 6'h00;
	logic [1:0] cc_i = 2'h0;
	logic [3:0] lat_i = 4'h0;
	logic [WORD_W-1:0] ps1_i = 32'h11112222;
	logic [WORD_W-1:0] ps2_i = 32'h33334444;
	logic busy_o, done_o, remote_exec_o, mem_req_o, mem_we_o, mem_ack_i;
	logic ps_load_o, order_req_o, order_ack_i;
	logic [ADDR_W-1:0] iaddr_o, mem_addr_o, order_addr_o, pc;
	logic [WORD_W-1:0] mem_wdata_o, mem_rdata_i, ps1_o, ps2_o, rv, pa, pb;
	int n_mismatch = 0;
	int checks = 0;
	cp_bit_branch_control_ops #(.INDEX_BIT(IB)) u_dut (.clk_i, .rst_i,
		.issue_i, .op_i, .reg_sel_i, .eff_addr_i, .shift_count_i, .cc_i,
		.busy_o, .done_o, .remote_exec_o, .iaddr_o, .mem_req_o, .mem_we_o,
		.mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i, .ps1_i, .ps2_i,
		.ps1_o, .ps2_o, .ps_load_o, .order_req_o, .order_addr_o,
		.order_ack_i);
	mem_order_model u_mem (.clk_i, .rst_i, .req_i(mem_req_o),
		.we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
		.ack_o(mem_ack_i), .rdata_o(mem_rdata_i), .oreq_i(order_req_o),
		.oaddr_i(order_addr_o), .oack_o(order_ack_i), .lat_i);
	always #50 clk_i = ~clk_i;
	task automatic summarize;
		if (n_mismatch == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [WORD_W-1:0] got, exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// issue stays high so single-cycle ops run back to back
	task automatic issue(input op_type op, input logic [REG_AW-1:0] r,
		input logic [ADDR_W-1:0] ea, input logic [1:0] cc);
		op_i = op;
		reg_sel_i = r;
		eff_addr_i = ea;
		cc_i = cc;
		issue_i = 1'b1;
		@(posedge clk_i);
		#1;
	endtask
	task automatic wait_done;
		int i;
		for (i = 0; i < 99 && done_o !== 1'b1; i++) begin
			@(posedge clk_i);
			#1;
			if (ps_load_o === 1'b1) begin
				pa = ps1_o;
				pb = ps2_o;
			end
		end
		if (i == 99) begin
			n_mismatch++;
			summarize();
		end
	endtask
	task automatic br(input op_type op, input logic [REG_AW-1:0] r,
		input logic [ADDR_W-1:0] ea, input logic [1:0] cc, input logic tk);
		issue(op, r, ea, cc);
		pc = tk ? ea : pc + 19'h1;
		chk(done_o, 1'b1);
		chk(iaddr_o, pc);
	endtask
	task automatic t_cc;
		logic [1:0] c;
		logic [7:0] tk;
		for (int k = 0; k < 4; k++) begin
			c = k[1:0];
			tk = {c != 2'b11, c == 2'b11, !c[1], c[1], !c[0], c[0],
				c != 2'b00, c == 2'b00};
			for (int j = 0; j < 8; j++)
				br(op_type'(OP_BRANCH_CC_EQUAL + j), 4'h0,
					ADDR_W'(32'h100 + k * 8 + j), c, tk[j]);
		end
	endtask
	task automatic regs;
		logic signed [WORD_W-1:0] s;
		s = rv;
		for (int j = 0; j < 6; j++)
			br(op_type'(OP_BRANCH_REG_ZERO + j), 4'h3, ADDR_W'(32'h200 + j),
				2'b00, j == 0 ? s == 0 : j == 1 ? s != 0 : j == 2 ? s > 0 :
				j == 3 ? s <= 0 : j == 4 ? s < 0 : s >= 0);
	endtask
	task automatic t_step;
		logic [WORD_W-1:0] nv;
		regs();
		for (int j = 5; j >= 0; j--) begin
			nv = j[0] ? rv - (1 << (j / 2)) : rv + (1 << (j / 2));
			br(op_type'(OP_STEP_UP_HALF_AND_BRANCH + j), 4'h3,
				ADDR_W'(32'h300 + j), 2'b00, nv[IB] == rv[IB]);
			rv = nv;
			regs();
		end
		rv = WORD_W'(pc) + 32'h1;
		br(OP_LINK_THEN_BRANCH, 4'h3, 19'h00400, 2'b00, 1'b1);
		regs();
	endtask
	// register 3 holds rv from the link, register 4 is still zero
	task automatic t_unpack;
		logic [2*WORD_W-1:0] pv;
		shift_count_i = 6'h18;
		pv = {32'h00000000, rv} << 24;
		issue(OP_UNPACK_LEFT, 4'h2, 19'h00000, 2'b00);
		pc = pc + 19'h1;
		chk(u_dut.regs_q[2], pv[63:32]);
		chk(u_dut.regs_q[3], pv[31:0]);
		pv = {pv[31:0], 32'h00000000} >> 24;
		issue(OP_UNPACK_RIGHT, 4'h3, 19'h00000, 2'b00);
		pc = pc + 19'h1;
		chk(u_dut.regs_q[3], pv[63:32]);
		chk(u_dut.regs_q[4], pv[31:0]);
		chk(iaddr_o, pc);
	endtask
	task automatic t_bit;
		logic [ADDR_W-1:0] ea;
		logic [WORD_W-1:0] w, m;
		int md, sk;
		logic b;
		for (int i = 0; i < 11; i++)
			for (int v = 0; v < 2; v++) begin
				ea = v ? 19'h00015 : 19'h00014;
				m = v ? 32'h00002000 : 32'h20000000;
				w = (i[0] ^ v[0]) ? 32'h5A5A5A5A | m : 32'h5A5A5A5A & ~m;
				b = (w & m) != 0;
				u_mem.mem[ea[4:1]] = w;
				lat_i = 4'(i % 3 * 2);
				sk = i < 3 ? 0 : i < 7 ? !b : b;
				md = i < 3 ? i : (i - 3) % 4 == 0 ? 3 : (i - 3) % 4 - 1;
				issue(op_type'(OP_CLEAR_SELECTED_BIT + i), 4'h2, ea, 2'b00);
				issue_i = 1'b0;
				wait_done();
				pc = pc + ADDR_W'(1 + sk);
				chk(iaddr_o, pc);
				chk(u_mem.mem[ea[4:1]], md == 0 ? w & ~m : md == 1 ? w | m :
					md == 2 ? w ^ m : w);
			end
	endtask
	task automatic t_order;
		lat_i = 4'h3;
		issue(OP_PROCESS_ORDER_SEND, 4'h0, 19'h0ABCD, 2'b00);
		issue(OP_BRANCH_CC_EQUAL, 4'h0, 19'h00777, 2'b00);
		issue_i = 1'b0;
		wait_done();
		pc = pc + 19'h1;
		chk(u_mem.oaddr_q, 19'h0ABCD);
		chk(iaddr_o, pc);
	endtask
	initial begin
		pc = '0;
		rv = '0;
		repeat (12) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		chk(iaddr_o, pc);
		t_cc();
		t_step();
		t_unpack();
		t_bit();
		t_order();
		issue(OP_EXECUTE_REMOTE_INSTRUCTION, 4'h0, 19'h00040, 2'b00);
		issue_i = 1'b0;
		chk(remote_exec_o, 1'b1);
		chk(iaddr_o, 19'h00040);
		u_mem.mem[6] = 32'hA5A50006;
		u_mem.mem[7] = 32'h5A5A0007;
		issue(OP_SWAP_PROGRAM_STATEWORDS, 4'h0, 19'h00006, 2'b00);
		issue_i = 1'b0;
		wait_done();
		chk(pa, 32'hA5A50006);
		chk(pb, 32'h5A5A0007);
		chk(u_mem.mem[6], ps1_i);
		chk(u_mem.mem[7], ps2_i);
		chk(iaddr_o, 19'h00041);
		summarize();
	end
endmodule
`default_nettype wire
